// ===== core/abu_address_break.sv
// address break unit: wishbone registers, bus comparator, break request
//
// The address map and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "abu_cfg.svh"

module abu_address_break (
  input wire logic clk,
  input wire logic reset,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // cpu internal bus, one cycle per access
  input wire logic cpuValid,
  input wire logic cpuFetch,
  input wire logic cpuRead,
  input wire logic cpuWrite,
  input wire logic cpuWord,
  input wire logic cpuIo8,
  input wire logic [15:0] cpuAddr,
  input wire logic [15:0] cpuData,
  // cpu instruction progress
  input wire logic cpuInstrDone,
  input wire logic cpuRteDone,
  // requests toward the cpu
  output logic breakIrq,
  output logic allIrqHold
);
  import abu_pkg::*;

  // ====================================================
  // register state
  logic rtIntEn_q, breakFlag_q, breakIe_q, flagSeen_q, resetHold_q, rteHold_q;
  logic splitRead_q, splitWrite_q;
  abu_cycle_t cycleSel_q;
  logic [2:0] addrSel_q;
  abu_dcmp_t dataSel_q;
  logic [15:0] breakAddr_q, breakData_q, splitAddr_q;
  abu_split_t split_q;
  logic [7:0] splitByte_q;

  // ====================================================
  // functions

  // mask of address bits that take part in the compare
  function automatic logic [15:0] addrMask(input logic [2:0] sel);
    logic [15:0] m;
    m = 16'hFFFF;
    unique case (sel)
      3'h1: m = 16'hFFF0;
      3'h2: m = 16'hFF00;
      3'h3: m = 16'hF000;
      // reserved codes fall back to a full compare
      default: m = 16'hFFFF;
    endcase
    return m;
  endfunction

  // data match on the lanes that carry data this cycle
  function automatic logic dataHit(
    input abu_dcmp_t sel,
    input logic [15:0] ref16,
    input logic [15:0] bus,
    input logic hiLane,
    input logic loLane
  );
    logic hit;
    hit = 1'b1;
    unique case (sel)
      ABU_DCMP_NONE: hit = 1'b1;
      ABU_DCMP_LOW: hit = loLane && (bus[7:0] == ref16[7:0]);
      ABU_DCMP_HIGH: hit = hiLane && (bus[15:8] == ref16[15:8]);
      ABU_DCMP_WORD: hit = hiLane && loLane && (bus == ref16);
    endcase
    return hit;
  endfunction

  // cycle type match for one observed access
  function automatic logic cycleHit(
    input abu_cycle_t sel,
    input logic fetch,
    input logic rd,
    input logic wr
  );
    logic hit;
    hit = 1'b0;
    unique case (sel)
      ABU_CYC_FETCH: hit = fetch;
      ABU_CYC_READ: hit = rd && !fetch;
      ABU_CYC_WRITE: hit = wr;
      ABU_CYC_RDWR: hit = (rd && !fetch) || wr;
    endcase
    return hit;
  endfunction

  // ====================================================
  // wishbone decode
  logic wbReq, wbWrite, wbRead;
  logic selCtl, selSts, selAddr, selData;

  // single-cycle request qualifier, one ack per request
  assign wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wbWrite = wbReq && wb_we_i;
  assign wbRead = wbReq && !wb_we_i;
  assign selCtl = (wb_adr_i == `ABU_OFS_CONTROL);
  assign selSts = (wb_adr_i == `ABU_OFS_STATUS);
  assign selAddr = (wb_adr_i == `ABU_OFS_ADDRESS);
  assign selData = (wb_adr_i == `ABU_OFS_DATA);

  // ack one cycle after the request; unmapped offsets ack and read zero
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wbReq;
    end
  end

  // ====================================================
  // register views
  logic [7:0] ctlView, stsView;

  assign ctlView = {rtIntEn_q, cycleSel_q, addrSel_q, dataSel_q};
  // reserved status bits always read as ones
  assign stsView = {breakFlag_q, breakIe_q, `ABU_RST_STS_RSVD};

  // read data registered with the ack
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wbRead) begin
      wb_dat_o <= 32'h0000_0000;
      if (selCtl) begin
        wb_dat_o[7:0] <= ctlView;
      end
      if (selSts) begin
        wb_dat_o[7:0] <= stsView;
      end
      if (selAddr) begin
        wb_dat_o[15:0] <= breakAddr_q;
      end
      if (selData) begin
        wb_dat_o[15:0] <= breakData_q;
      end
    end
  end

  // ====================================================
  // control register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rtIntEn_q <= 1'b1;
      cycleSel_q <= ABU_CYC_FETCH;
      addrSel_q <= 3'h0;
      dataSel_q <= ABU_DCMP_NONE;
    end else if (wbWrite && selCtl && wb_sel_i[0]) begin
      rtIntEn_q <= wb_dat_i[`ABU_CTL_RTINT_BIT];
      cycleSel_q <= abu_cycle_t'(wb_dat_i[`ABU_CTL_CSEL_HI:`ABU_CTL_CSEL_LO]);
      // 1XX is never written by correct software
      addrSel_q <= wb_dat_i[`ABU_CTL_ACMP_HI:`ABU_CTL_ACMP_LO];
      dataSel_q <= abu_dcmp_t'(wb_dat_i[`ABU_CTL_DCMP_HI:`ABU_CTL_DCMP_LO]);
    end
  end

  // break address, byte lanes 0 and 1
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      breakAddr_q <= `ABU_RST_ADDRESS;
    end else if (wbWrite && selAddr) begin
      if (wb_sel_i[0]) begin
        breakAddr_q[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        breakAddr_q[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  // break data; low and high byte compares use bits 7:0 and 15:8
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      breakData_q <= `ABU_RST_DATA;
    end else if (wbWrite && selData) begin
      if (wb_sel_i[0]) begin
        breakData_q[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        breakData_q[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  // ====================================================
  // word access to 8-bit i/o: replay the odd byte next cycle
  logic ioSplit;

  assign ioSplit = cpuValid && cpuWord && cpuIo8 && (split_q == ABU_SPL_IDLE);

  // second byte carries the odd address and the low data byte
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      split_q <= ABU_SPL_IDLE;
      splitAddr_q <= 16'h0000;
      splitByte_q <= 8'h00;
      splitRead_q <= 1'b0;
      splitWrite_q <= 1'b0;
    end else begin
      unique case (split_q)
        ABU_SPL_IDLE: begin
          if (ioSplit && !cpuFetch) begin
            split_q <= ABU_SPL_SECOND;
            splitAddr_q <= {cpuAddr[15:1], 1'b1};
            splitByte_q <= cpuData[7:0];
            splitRead_q <= cpuRead;
            splitWrite_q <= cpuWrite;
          end
        end
        ABU_SPL_SECOND: begin
          split_q <= ABU_SPL_IDLE;
        end
      endcase
    end
  end

  // ====================================================
  // comparator inputs for this cycle
  logic obsValid, obsFetch, obsRead, obsWrite, laneHi, laneLo;
  logic [15:0] obsAddr, obsData;

  // the replayed byte takes priority; a new access in that cycle is not compared
  always_comb begin
    obsValid = cpuValid;
    obsFetch = cpuFetch;
    obsRead = cpuRead;
    obsWrite = cpuWrite;
    obsAddr = cpuAddr;
    obsData = cpuData;
    laneHi = 1'b1;
    laneLo = 1'b1;
    if (split_q == ABU_SPL_SECOND) begin
      obsValid = 1'b1;
      obsFetch = 1'b0;
      obsRead = splitRead_q;
      obsWrite = splitWrite_q;
      obsAddr = splitAddr_q;
      obsData = {splitByte_q, 8'h00};
      laneLo = 1'b0;
    end else if (cpuIo8 && !cpuFetch) begin
      // first byte of 8-bit i/o access rides the upper lane
      obsData = {cpuData[15:8], 8'h00};
      laneLo = 1'b0;
    end else if (!cpuWord && !cpuFetch) begin
      laneLo = 1'b0;
    end else if (cpuWord && cpuAddr[0] && !cpuFetch) begin
      laneHi = 1'b0;
    end
  end

  // ====================================================
  // match decision, all terms from the same cycle
  logic addrHit, matchNow;

  assign addrHit = ((obsAddr ^ breakAddr_q) & addrMask(addrSel_q)) == 16'h0000;
  // fetch breaks compare address and cycle only
  assign matchNow = obsValid && addrHit
    && cycleHit(cycleSel_q, obsFetch, obsRead, obsWrite)
    && (obsFetch || dataHit(dataSel_q, breakData_q, obsData, laneHi, laneLo));

  // ====================================================
  // break flag and enable
  logic stsWrite, flagClear;

  assign stsWrite = wbWrite && selSts && wb_sel_i[0];
  assign flagClear = stsWrite && !wb_dat_i[`ABU_STS_FLAG_BIT] && flagSeen_q;

  // remember that software saw the flag set
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      flagSeen_q <= 1'b0;
    end else if (stsWrite || !breakFlag_q) begin
      flagSeen_q <= 1'b0;
    end else if (wbRead && selSts) begin
      flagSeen_q <= 1'b1;
    end
  end

  // a match in the clearing cycle wins over the clear
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      breakFlag_q <= 1'b0;
    end else if (matchNow) begin
      breakFlag_q <= 1'b1;
    end else if (flagClear) begin
      breakFlag_q <= 1'b0;
    end
  end

  // writing a one to the flag has no effect
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      breakIe_q <= 1'b0;
    end else if (stsWrite) begin
      breakIe_q <= wb_dat_i[`ABU_STS_IE_BIT];
    end
  end

  // ====================================================
  // interrupt gating around reset and return-from-exception

  // stack pointer is not set up until the first instruction runs
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      resetHold_q <= 1'b1;
    end else if (cpuInstrDone) begin
      resetHold_q <= 1'b0;
    end
  end

  // with rtIntEn_q clear, one instruction must run after a return before a new request
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rteHold_q <= 1'b0;
    end else if (cpuRteDone) begin
      rteHold_q <= !rtIntEn_q;
    end else if (cpuInstrDone) begin
      rteHold_q <= 1'b0;
    end
  end

  // global hold covers every source, the non-maskable one included
  assign allIrqHold = resetHold_q;

  // no global mask input: the cpu must take this regardless; it
  // begins exception handling only at instruction end
  assign breakIrq = breakFlag_q && breakIe_q
    && !resetHold_q && !rteHold_q;

endmodule // abu_address_break

`default_nettype wire

// ===== core/abu_cfg.svh
// address break unit: register offsets, field positions and reset values
`ifndef ABU_CFG_SVH
`define ABU_CFG_SVH

// ====================================================
// register byte offsets on the wishbone slave
`define ABU_OFS_CONTROL 4'h0
`define ABU_OFS_STATUS 4'h4
`define ABU_OFS_ADDRESS 4'h8
`define ABU_OFS_DATA 4'hC

// ====================================================
// break_condition_control field positions
`define ABU_CTL_RTINT_BIT 7
`define ABU_CTL_CSEL_HI 6
`define ABU_CTL_CSEL_LO 5
`define ABU_CTL_ACMP_HI 4
`define ABU_CTL_ACMP_LO 2
`define ABU_CTL_DCMP_HI 1
`define ABU_CTL_DCMP_LO 0

// ====================================================
// break_status field positions
`define ABU_STS_FLAG_BIT 7
`define ABU_STS_IE_BIT 6

// ====================================================
// reset values
`define ABU_RST_CONTROL 8'h80
`define ABU_RST_STS_RSVD 6'h3F
`define ABU_RST_ADDRESS 16'hFFFF
`define ABU_RST_DATA 16'h0000

`endif

// ===== core/abu_pkg.sv
// address break unit: shared types
package abu_pkg;

  // ====================================================
  // break cycle type select
  typedef enum logic [1:0] {
    ABU_CYC_FETCH = 2'h0,
    ABU_CYC_READ = 2'h1,
    ABU_CYC_WRITE = 2'h2,
    ABU_CYC_RDWR = 2'h3
  } abu_cycle_t;

  // ====================================================
  // data compare select
  typedef enum logic [1:0] {
    ABU_DCMP_NONE = 2'h0,
    ABU_DCMP_LOW = 2'h1,
    ABU_DCMP_HIGH = 2'h2,
    ABU_DCMP_WORD = 2'h3
  } abu_dcmp_t;

  // ====================================================
  // splitter for word access to 8-bit i/o space
  typedef enum logic [1:0] {
    ABU_SPL_IDLE = 2'b01,
    ABU_SPL_SECOND = 2'b10
  } abu_split_t;

endpackage

// ===== dv/abu_cpu_model.sv
// cpu core model driving the internal buses and instruction progress
`timescale 1ns/1ps
`default_nettype none
module abu_cpu_model (
  input wire logic clk,
  output logic cpuValid,
  output logic cpuFetch,
  output logic cpuRead,
  output logic cpuWrite,
  output logic cpuWord,
  output logic cpuIo8,
  output logic [15:0] cpuAddr,
  output logic [15:0] cpuData,
  output logic cpuInstrDone,
  output logic cpuRteDone
);
  // ====
  // idle at time zero
  initial begin
    {cpuValid, cpuFetch, cpuRead, cpuWrite, cpuWord, cpuIo8} = 6'h00;
    {cpuAddr, cpuData, cpuInstrDone, cpuRteDone} = 34'h0;
  end
  // one access cycle; k is fetch, read, write, word, io8
  task automatic access(input logic [4:0] k, input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    cpuValid <= 1'b1;
    {cpuFetch, cpuRead, cpuWrite, cpuWord, cpuIo8} <= k;
    cpuAddr <= a;
    cpuData <= d;
    @(posedge clk);
    cpuValid <= 1'b0;
    {cpuFetch, cpuRead, cpuWrite, cpuWord, cpuIo8} <= 5'h00;
    // idle buses carry the inverse so a stale copy never matches
    cpuAddr <= ~a;
    cpuData <= ~d;
  endtask
  // one-cycle completion pulses
  task automatic step(input logic i, input logic r);
    @(posedge clk);
    cpuInstrDone <= i;
    cpuRteDone <= r;
    @(posedge clk);
    cpuInstrDone <= 1'b0;
    cpuRteDone <= 1'b0;
  endtask
endmodule // abu_cpu_model
`default_nettype wire

// ===== dv/abu_properties.sv
// checker on the ports of the address break unit
`timescale 1ns/1ps
`default_nettype none
`include "abu_cfg.svh"
module abu_properties (
  input wire logic clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic cpuValid,
  input wire logic cpuInstrDone,
  input wire logic cpuRteDone,
  input wire logic breakIrq,
  input wire logic allIrqHold
);
  // ====
  // single domain, reset silences everything
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held past one cycle");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  a_hold_gate: assert property (allIrqHold |-> !breakIrq)
    else $error("break request while held");
  a_hold_release: assert property ($fell(allIrqHold) |-> $past(cpuInstrDone))
    else $error("hold dropped without instruction");
  a_hold_stays: assert property (!allIrqHold |=> !allIrqHold)
    else $error("hold came back without reset");
  // replay cycle follows an 8-bit i/o word, hence depth two
  a_irq_cause: assert property ($rose(breakIrq) |-> $past(cpuValid) ||
    $past(cpuValid, 2) || $past(wb_stb_i) || $past(cpuInstrDone))
    else $error("break request rose without cause");
  a_irq_drop: assert property ($fell(breakIrq) |->
    $past(wb_stb_i && wb_we_i) || $past(cpuRteDone))
    else $error("break request fell without cause");
  a_status_ones: assert property (wb_ack_o &&
    $past(wb_adr_i == `ABU_OFS_STATUS && !wb_we_i) |-> wb_dat_o[5:0] == 6'h3F)
    else $error("status reserved bits not ones");
endmodule // abu_properties
bind abu_address_break abu_properties chk_u (.clk, .reset, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .cpuValid, .cpuInstrDone, .cpuRteDone,
  .breakIrq, .allIrqHold);
`default_nettype wire

// ===== dv/test_address_break_unit.sv
// self-checking bench of the address break unit
`timescale 1ns/1ps
`default_nettype none
`include "abu_cfg.svh"
module test_address_break_unit;
  import abu_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, cpuValid, cpuFetch, cpuRead, cpuWrite, cpuWord, cpuIo8;
  wire cpuInstrDone, cpuRteDone, breakIrq, allIrqHold;
  wire [15:0] cpuAddr, cpuData;
  int err_count = 0;
  int n_tests = 0;
  logic [31:0] q;
  logic [83:0] r;
  // ====
  // rows: control, address, data, access kind, bus address, bus data, flag
  localparam logic [83:0] ROWS [20] = '{
    84'h80_1234_0000_10_1234_0000_1, 84'h80_1234_0000_0A_1234_0000_0,
    84'hA0_1234_0000_10_1234_0000_0, 84'hA0_1234_0000_0A_1234_FFFF_1,
    84'hC0_1234_0000_0A_1234_0000_0, 84'hC0_1234_0000_04_1234_0000_1,
    84'hE0_1234_0000_04_1234_0000_1, 84'h84_1234_0000_10_123F_0000_1,
    84'h80_1234_0000_10_1235_0000_0, 84'h88_1234_0000_10_12FF_0000_1,
    84'h8C_1234_0000_10_1FFF_0000_1, 84'h8C_1234_0000_10_2234_0000_0,
    84'hA3_1234_5A6B_0A_1234_5A6B_1, 84'hA3_1234_5A6B_0A_1234_5A6C_0,
    84'hA5_1235_5A6B_0A_1235_006B_1, 84'hA6_1235_5A6B_0A_1235_5A00_0,
    84'hA6_1235_5A6B_08_1235_5AFF_1, 84'hA5_1235_5A6B_08_1235_006B_0,
    84'hA2_1235_5A00_0B_1234_115A_1, 84'hA1_1234_006B_0B_1234_006B_0};
  // offset and reset value; 0x1 is unmapped
  localparam logic [19:0] RV [5] = '{20'h0_0080, 20'h4_003F, 20'h8_FFFF, 20'hC_0000,
    20'h1_0000};
  abu_address_break dut_u (.clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .cpuValid, .cpuFetch, .cpuRead,
    .cpuWrite, .cpuWord, .cpuIo8, .cpuAddr, .cpuData, .cpuInstrDone, .cpuRteDone,
    .breakIrq, .allIrqHold);
  abu_cpu_model cpu_u (.clk, .cpuValid, .cpuFetch, .cpuRead, .cpuWrite, .cpuWord,
    .cpuIo8, .cpuAddr, .cpuData, .cpuInstrDone, .cpuRteDone);
  // ====
  // 125 MHz
  always #4 clk = ~clk;
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", nm, exp, got);
      err_count++;
    end
  endtask
  // classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [3:0] a, input logic [15:0] d,
    output logic [31:0] rd);
    @(posedge clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i} <= {2'b11, w, a, 4'h3};
    wb_dat_i <= {16'h0000, d};
    // no cycle count assumed; only the watchdog ends a wait
    do begin
      @(posedge clk);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  // request pins away from the edge
  task automatic pins(input logic [1:0] e);
    @(negedge clk);
    chk("hold,irq", {30'h0, allIrqHold, breakIrq}, {30'h0, e});
  endtask
  task automatic test_done;
    $display("tests %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // watchdog far beyond the few hundred cycles needed
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    test_done;
  end
  // ====
  // table, then reset, flag clearing and request gating
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 20; i++) begin
      r = ROWS[i];
      wb(1'b1, `ABU_OFS_CONTROL, {8'h00, r[83:76]}, q);
      wb(1'b1, `ABU_OFS_ADDRESS, r[75:60], q);
      wb(1'b1, `ABU_OFS_DATA, r[59:44], q);
      cpu_u.access(r[40:36], r[35:20], r[19:4]);
      wb(1'b0, `ABU_OFS_STATUS, 16'h0, q);
      chk("flag", q, {24'h0, r[0], 7'h3F});
      wb(1'b1, `ABU_OFS_STATUS, 16'h0, q);
    end
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    pins(2'b10);
    wb(1'b1, 4'h1, 16'hFFFF, q);
    for (int j = 0; j < 5; j++) begin
      wb(1'b0, RV[j][19:16], 16'h0, q);
      chk("reset value", q, {16'h0, RV[j][15:0]});
    end
    wb(1'b1, `ABU_OFS_ADDRESS, 16'h1234, q);
    cpu_u.access(5'h10, 16'h1234, 16'h0);
    // zero written to the flag without a read must not clear it
    wb(1'b1, `ABU_OFS_STATUS, 16'h0040, q);
    pins(2'b10);
    cpu_u.step(1'b1, 1'b0);
    pins(2'b01);
    cpu_u.step(1'b0, 1'b1);
    pins(2'b01);
    wb(1'b1, `ABU_OFS_CONTROL, 16'h0000, q);
    cpu_u.step(1'b0, 1'b1);
    pins(2'b00);
    cpu_u.step(1'b1, 1'b0);
    pins(2'b01);
    wb(1'b1, `ABU_OFS_STATUS, 16'h0000, q);
    pins(2'b00);
    wb(1'b0, `ABU_OFS_STATUS, 16'h0, q);
    chk("flag kept", q, 32'h0000_00BF);
    wb(1'b1, `ABU_OFS_STATUS, 16'h0, q);
    wb(1'b0, `ABU_OFS_STATUS, 16'h0, q);
    chk("flag cleared", q, 32'h0000_003F);
    test_done;
  end
endmodule // test_address_break_unit
`default_nettype wire
